//--- bcf_pkg.sv
package bcf_pkg;
	// Table base word indices (byte address divided by four)
	localparam logic [15:0] BCF_DISC_TABLE_IDX = 16'h5100;
	localparam logic [15:0] BCF_DISC_BITMAP_IDX = 16'h5200;
	localparam logic [15:0] BCF_ALARM_TABLE_IDX = 16'h5500;
	localparam logic [15:0] BCF_VER_ERR_IDX = 16'h5700;
	// Table lengths in words
	localparam int BCF_DISC_TABLE_LEN = 256;
	localparam int BCF_DISC_BITMAP_LEN = 128;
	localparam int BCF_ALARM_TABLE_LEN = 256;
	localparam int BCF_VER_ERR_LEN = 128;
	// Own control and status registers (word indices)
	localparam logic [15:0] BCF_CMD_IDX = 16'h0000;
	localparam logic [15:0] BCF_STATUS_IDX = 16'h0001;
	localparam logic [15:0] BCF_ERRCODE_IDX = 16'h0002;
	localparam logic [15:0] BCF_ERRID_IDX = 16'h0003;
	localparam logic [15:0] BCF_ALMCODE_IDX = 16'h0004;
	localparam logic [15:0] BCF_ALMID_IDX = 16'h0005;
	localparam logic [15:0] BCF_LOSTCNT_IDX = 16'h0006;
	localparam logic [15:0] BCF_ALMCNT_IDX = 16'h0007;
	localparam logic [15:0] BCF_IRQ_STAT_IDX = 16'h0008;
	localparam logic [15:0] BCF_IRQ_EN_IDX = 16'h0009;
	localparam logic [15:0] BCF_IRQ_CLR_IDX = 16'h000a;
	localparam logic [15:0] BCF_OUT_BASE_IDX = 16'h0020;
	localparam int BCF_OUT_WORDS = 32;
	// Command register bit positions
	localparam int BCF_CMD_CLEAR = 0;
	localparam int BCF_CMD_ADDR_DET = 1;
	localparam int BCF_CMD_ADDR_CHK = 2;
	localparam int BCF_CMD_COMMIT = 12;
	localparam int BCF_CMD_VER_CHK = 13;
	localparam int BCF_CMD_SLV_ACC = 16;
	localparam int BCF_CMD_BATCH_RD = 17;
	localparam int BCF_CMD_BATCH_WR = 18;
	localparam int BCF_NUM_CMDS = 8;
	// Status flag positions
	localparam int BCF_ST_LINE_SHORT = 1;
	localparam int BCF_ST_SUPPLY_SHORT = 2;
	localparam int BCF_ST_LINE_BREAK = 4;
	localparam int BCF_ST_ERROR = 5;
	localparam int BCF_ST_ALARM = 6;
	localparam int BCF_ST_VER_MISMATCH = 8;
	localparam int BCF_ST_SLAVE_ALARM = 16;
	localparam int BCF_ST_PARAM_DONE = 17;
	localparam int BCF_ST_PARAM_FAULT = 18;
	// Mask of flags a clear resets
	localparam logic [31:0] BCF_CLEAR_MASK = 32'h0005_0176;
	localparam logic [15:0] BCF_ZERO16 = 16'h0000;
	localparam logic [31:0] BCF_ZERO32 = 32'h0000_0000;
endpackage

//--- bcf_bridge.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module bcf_bridge
	import bcf_pkg::*;
#(
	parameter int POINTS = 512,
	parameter int EW = 16
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [17:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Events from the slave line engines
	input wire logic [31:0] flag_set_i,
	input wire logic err_load_i,
	input wire logic [EW-1:0] err_code_i,
	input wire logic [EW-1:0] err_id_i,
	input wire logic alm_load_i,
	input wire logic [EW-1:0] alm_code_i,
	input wire logic [EW-1:0] alm_id_i,
	input wire logic lost_inc_i,
	input wire logic alm_inc_i,
	input wire logic tbl_we_i,
	input wire logic [1:0] tbl_sel_i,
	input wire logic [7:0] tbl_adr_i,
	input wire logic [EW-1:0] tbl_dat_i,
	// Action start pulses and the commit pending level
	output logic addr_detect_start_o,
	output logic addr_check_start_o,
	output logic param_commit_start_o,
	output logic version_check_start_o,
	output logic slave_param_start_o,
	output logic batch_read_start_o,
	output logic batch_write_start_o,
	output logic commit_pending_o,
	// Slave outputs and interrupt
	output logic [POINTS-1:0] output_point_area_o,
	output logic irq_o
);
	// Sixteen points per output word
	localparam int OW = POINTS / 16;

	// Command and status words
	logic [31:0] cmd, next_cmd, status, next_status;

	// Error side words and counters
	logic [EW-1:0] err_code, err_id, alm_code, alm_id;
	logic [EW-1:0] next_err_code, next_err_id, next_alm_code, next_alm_id;
	logic [EW-1:0] lost_cnt, next_lost_cnt, alm_cnt, next_alm_cnt;

	// Tables, one word per entry
	logic [EW-1:0] disc_tbl [BCF_DISC_TABLE_LEN];
	logic [EW-1:0] disc_bmp [BCF_DISC_BITMAP_LEN];
	logic [EW-1:0] alm_tbl [BCF_ALARM_TABLE_LEN];
	logic [EW-1:0] ver_tbl [BCF_VER_ERR_LEN];
	logic [EW-1:0] next_disc_tbl [BCF_DISC_TABLE_LEN];
	logic [EW-1:0] next_disc_bmp [BCF_DISC_BITMAP_LEN];
	logic [EW-1:0] next_alm_tbl [BCF_ALARM_TABLE_LEN];
	logic [EW-1:0] next_ver_tbl [BCF_VER_ERR_LEN];

	// Output points, interrupt bits and pending commit
	logic [POINTS-1:0] outs, next_outs;
	logic [BCF_NUM_CMDS-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en;
	logic commit_pend, next_commit_pend;

	// Bus answer and decode
	logic ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic [BCF_NUM_CMDS-1:0] edges;
	logic clr_go, err_clr_ok, wr, rd;
	logic [15:0] idx;

	// Word index; ack blocks a second take of one request
	assign idx = adr_i[17:2];
	assign wr = cyc_i && stb_i && we_i && !ack;
	assign rd = cyc_i && stb_i && !we_i && !ack;

	// Rising edges of command bits against previous value
	always_comb begin
		edges[0] = next_cmd[BCF_CMD_CLEAR] && !cmd[BCF_CMD_CLEAR];
		edges[1] = next_cmd[BCF_CMD_ADDR_DET] && !cmd[BCF_CMD_ADDR_DET];
		edges[2] = next_cmd[BCF_CMD_ADDR_CHK] && !cmd[BCF_CMD_ADDR_CHK];
		edges[3] = next_cmd[BCF_CMD_COMMIT] && !cmd[BCF_CMD_COMMIT];
		edges[4] = next_cmd[BCF_CMD_VER_CHK] && !cmd[BCF_CMD_VER_CHK];
		edges[5] = next_cmd[BCF_CMD_SLV_ACC] && !cmd[BCF_CMD_SLV_ACC];
		edges[6] = next_cmd[BCF_CMD_BATCH_RD] && !cmd[BCF_CMD_BATCH_RD];
		edges[7] = next_cmd[BCF_CMD_BATCH_WR] && !cmd[BCF_CMD_BATCH_WR];
	end

	// Clear only when an error or alarm is present
	assign clr_go = edges[0] && (status[BCF_ST_ERROR] ||
		status[BCF_ST_ALARM]);
	assign err_clr_ok = status[BCF_ST_PARAM_DONE];

	// Bus writes to command and output area
	always_comb begin
		next_cmd = cmd;
		next_outs = outs;
		if (wr && idx == BCF_CMD_IDX)
			next_cmd = dat_i;
		if (wr && idx >= BCF_OUT_BASE_IDX &&
			idx < BCF_OUT_BASE_IDX + 16'(OW)) begin
			// point = 16 * word + bit; by address
			for (int b = 0; b < 16; b++)
				if (sel_i[b/8])
					next_outs[16*int'(idx - BCF_OUT_BASE_IDX) + b] =
						dat_i[b];
		end
	end

	// Action pulses, one per edge except the clear edge
	// They stand only while the command write is presented
	always_comb begin
		addr_detect_start_o = ce_i && edges[1];
		addr_check_start_o = ce_i && edges[2];
		param_commit_start_o = ce_i && edges[3];
		version_check_start_o = ce_i && edges[4];
		slave_param_start_o = ce_i && edges[5];
		batch_read_start_o = ce_i && edges[6];
		batch_write_start_o = ce_i && edges[7];
	end

	// Status flags, words and counters
	// Engine events land first; a clear in that cycle wins
	always_comb begin
		next_status = status | flag_set_i;
		next_err_code = err_load_i ? err_code_i : err_code;
		next_err_id = err_load_i ? err_id_i : err_id;
		next_alm_code = alm_load_i ? alm_code_i : alm_code;
		next_alm_id = alm_load_i ? alm_id_i : alm_id;
		next_lost_cnt = lost_inc_i ? lost_cnt + 1'b1 : lost_cnt;
		next_alm_cnt = alm_inc_i ? alm_cnt + 1'b1 : alm_cnt;
		if (clr_go) begin
			next_status = next_status & ~(BCF_CLEAR_MASK &
				~(err_clr_ok ? BCF_ZERO32 :
				(32'h1 << BCF_ST_ERROR)));
			next_alm_code = BCF_ZERO16;
			next_alm_id = BCF_ZERO16;
			next_alm_cnt = BCF_ZERO16;
			if (err_clr_ok) begin
				next_err_code = BCF_ZERO16;
				next_err_id = BCF_ZERO16;
				next_lost_cnt = BCF_ZERO16;
			end
		end
	end

	// Commit held until reset makes it effective
	// The storage copy runs outside; this only drives commit_pending_o, which no bus word reads
	always_comb begin
		next_commit_pend = commit_pend || edges[3];
	end

	// Interrupt status: set wins over clear
	// Bit order follows the command edge order
	always_comb begin
		next_irq_en = irq_en;
		next_irq_stat = irq_stat;
		if (wr && idx == BCF_IRQ_EN_IDX)
			next_irq_en = dat_i[BCF_NUM_CMDS-1:0];
		if (wr && idx == BCF_IRQ_CLR_IDX)
			next_irq_stat = irq_stat & ~dat_i[BCF_NUM_CMDS-1:0];
		next_irq_stat = next_irq_stat | edges;
	end

	// Bus read mux
	// Unmapped words read zero but are still answered
	always_comb begin
		next_ack = cyc_i && stb_i && !ack;
		next_rdata = rdata;
		if (rd) begin
			next_rdata = BCF_ZERO32;
			unique case (1'b1)
				idx == BCF_CMD_IDX: next_rdata = cmd;
				idx == BCF_STATUS_IDX: next_rdata = status;
				idx == BCF_ERRCODE_IDX: next_rdata[EW-1:0] = err_code;
				idx == BCF_ERRID_IDX: next_rdata[EW-1:0] = err_id;
				idx == BCF_ALMCODE_IDX: next_rdata[EW-1:0] = alm_code;
				idx == BCF_ALMID_IDX: next_rdata[EW-1:0] = alm_id;
				idx == BCF_LOSTCNT_IDX: next_rdata[EW-1:0] = lost_cnt;
				idx == BCF_ALMCNT_IDX: next_rdata[EW-1:0] = alm_cnt;
				idx == BCF_IRQ_STAT_IDX:
					next_rdata[BCF_NUM_CMDS-1:0] = irq_stat;
				idx == BCF_IRQ_EN_IDX:
					next_rdata[BCF_NUM_CMDS-1:0] = irq_en;
				idx >= BCF_OUT_BASE_IDX &&
					idx < BCF_OUT_BASE_IDX + 16'(OW):
					next_rdata[15:0] = outs[16*int'(idx -
						BCF_OUT_BASE_IDX) +: 16];
				idx >= BCF_DISC_TABLE_IDX && idx < BCF_DISC_TABLE_IDX +
					16'(BCF_DISC_TABLE_LEN):
					next_rdata[EW-1:0] =
						disc_tbl[8'(idx - BCF_DISC_TABLE_IDX)];
				idx >= BCF_DISC_BITMAP_IDX && idx < BCF_DISC_BITMAP_IDX +
					16'(BCF_DISC_BITMAP_LEN):
					next_rdata[EW-1:0] =
						disc_bmp[7'(idx - BCF_DISC_BITMAP_IDX)];
				idx >= BCF_ALARM_TABLE_IDX && idx < BCF_ALARM_TABLE_IDX +
					16'(BCF_ALARM_TABLE_LEN):
					next_rdata[EW-1:0] =
						alm_tbl[8'(idx - BCF_ALARM_TABLE_IDX)];
				idx >= BCF_VER_ERR_IDX && idx < BCF_VER_ERR_IDX +
					16'(BCF_VER_ERR_LEN):
					next_rdata[EW-1:0] =
						ver_tbl[7'(idx - BCF_VER_ERR_IDX)];
				default: next_rdata = BCF_ZERO32;
			endcase
		end
	end

	// Command word and output points
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd <= BCF_ZERO32;
			outs <= '0;
		end else if (ce_i) begin
			cmd <= next_cmd;
			outs <= next_outs;
		end
	end

	// Status flags, last codes and counters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= BCF_ZERO32;
			err_code <= BCF_ZERO16;
			err_id <= BCF_ZERO16;
			alm_code <= BCF_ZERO16;
			alm_id <= BCF_ZERO16;
			lost_cnt <= BCF_ZERO16;
			alm_cnt <= BCF_ZERO16;
		end else if (ce_i) begin
			status <= next_status;
			err_code <= next_err_code;
			err_id <= next_err_id;
			alm_code <= next_alm_code;
			alm_id <= next_alm_id;
			lost_cnt <= next_lost_cnt;
			alm_cnt <= next_alm_cnt;
		end
	end

	// Interrupt bits and pending commit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= '0;
			irq_en <= '0;
			commit_pend <= 1'b0;
		end else if (ce_i) begin
			irq_stat <= next_irq_stat;
			irq_en <= next_irq_en;
			commit_pend <= next_commit_pend;
		end
	end

	// Bus answer and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			rdata <= BCF_ZERO32;
		end else if (ce_i) begin
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	// Table next values: engine write, then a clear that wins
	always_comb begin
		next_disc_tbl = disc_tbl;
		next_disc_bmp = disc_bmp;
		next_alm_tbl = alm_tbl;
		next_ver_tbl = ver_tbl;
		if (tbl_we_i) begin
			unique case (tbl_sel_i)
				2'h0: next_disc_tbl[tbl_adr_i] = tbl_dat_i;
				2'h1: next_disc_bmp[tbl_adr_i[6:0]] = tbl_dat_i;
				2'h2: next_alm_tbl[tbl_adr_i] = tbl_dat_i;
				2'h3: next_ver_tbl[tbl_adr_i[6:0]] = tbl_dat_i;
			endcase
		end
		if (clr_go) begin
			for (int i = 0; i < BCF_DISC_TABLE_LEN; i++)
				next_disc_tbl[i] = BCF_ZERO16;
			for (int i = 0; i < BCF_DISC_BITMAP_LEN; i++)
				next_disc_bmp[i] = BCF_ZERO16;
			for (int i = 0; i < BCF_ALARM_TABLE_LEN; i++)
				next_alm_tbl[i] = BCF_ZERO16;
			for (int i = 0; i < BCF_VER_ERR_LEN; i++)
				next_ver_tbl[i] = BCF_ZERO16;
		end
	end

	// Table registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < BCF_DISC_TABLE_LEN; i++)
				disc_tbl[i] <= BCF_ZERO16;
			for (int i = 0; i < BCF_DISC_BITMAP_LEN; i++)
				disc_bmp[i] <= BCF_ZERO16;
			for (int i = 0; i < BCF_ALARM_TABLE_LEN; i++)
				alm_tbl[i] <= BCF_ZERO16;
			for (int i = 0; i < BCF_VER_ERR_LEN; i++)
				ver_tbl[i] <= BCF_ZERO16;
		end else if (ce_i) begin
			disc_tbl <= next_disc_tbl;
			disc_bmp <= next_disc_bmp;
			alm_tbl <= next_alm_tbl;
			ver_tbl <= next_ver_tbl;
		end
	end

	// Outputs straight from registers; interrupt is a level
	assign dat_o = rdata;
	assign ack_o = ack;
	assign output_point_area_o = outs;
	assign commit_pending_o = commit_pend;
	assign irq_o = |(irq_stat & irq_en);
endmodule

//--- bcf_properties.sv
`timescale 1ns/1ps
module bcf_props
	import bcf_pkg::*;
(
	// Bus side
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [17:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// Action side
	input wire logic addr_detect_start_o,
	input wire logic addr_check_start_o,
	input wire logic param_commit_start_o,
	input wire logic version_check_start_o,
	input wire logic batch_read_start_o,
	input wire logic commit_pending_o
);
	// Request waiting for its answer, and the command write among them
	wire logic rq = cyc_i && stb_i && !ack_o && ce_i;
	wire logic cw = rq && we_i && adr_i[17:2] == BCF_CMD_IDX;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (rq |=> ack_o)
		else $error("request not answered");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("answer too long");
	a_detect_cause: assert property (
		addr_detect_start_o |-> cw && dat_i[1])
		else $error("detect start without command");
	a_check_cause: assert property (addr_check_start_o |-> cw && dat_i[2])
		else $error("check start without command");
	a_version_cause: assert property (
		version_check_start_o |-> cw && dat_i[13])
		else $error("version start without command");
	a_batch_cause: assert property (
		batch_read_start_o |-> cw && dat_i[17])
		else $error("batch start without command");
	a_start_once: assert property (
		param_commit_start_o |=> !param_commit_start_o)
		else $error("commit start repeated");
	a_commit_pend: assert property (
		param_commit_start_o |=> commit_pending_o)
		else $error("commit not pending");
	a_pend_hold: assert property (commit_pending_o |=> commit_pending_o)
		else $error("commit dropped before reset");
endmodule
bind bcf_bridge bcf_props i_chk (.*);

//--- bcf_engine_model.sv
`timescale 1ns/1ps
module bcf_engine_model #(
	parameter int DLY = 3,
	parameter logic [15:0] CODE = 16'h0c01
) (
	// Clock and started actions
	input wire logic clk_i,
	input wire logic det_i,
	input wire logic chk_i,
	input wire logic prm_i,
	// Events toward the bridge
	output logic [31:0] flag_set_o,
	output logic err_load_o,
	output logic alm_load_o,
	output logic lost_inc_o,
	output logic alm_inc_o,
	output logic tbl_we_o,
	output logic [1:0] tbl_sel_o,
	output logic [15:0] code_o,
	output logic [15:0] id_o
);
	logic [2:0] k;
	// Answer a started run after a delay with one cycle of events
	initial begin
		{flag_set_o, err_load_o, alm_load_o, lost_inc_o} = '0;
		{alm_inc_o, tbl_we_o, tbl_sel_o, code_o, id_o} = '0;
		forever begin
			@(posedge clk_i);
			k = {prm_i, chk_i, det_i};
			if (k != 3'h0) begin
				repeat (DLY) @(posedge clk_i);
				flag_set_o <= k[0] ? 32'h22 : k[1] ? 32'h1_0040 : 32'h2_0000;
				{err_load_o, lost_inc_o} <= {2{k[0]}};
				{alm_load_o, alm_inc_o} <= {2{k[1]}};
				tbl_we_o <= k[0] | k[1];
				tbl_sel_o <= {k[1], 1'b0};
				code_o <= CODE;
				id_o <= 16'h0fff;
				@(posedge clk_i);
				{flag_set_o, err_load_o, alm_load_o, lost_inc_o} <= '0;
				{alm_inc_o, tbl_we_o} <= '0;
				code_o <= ~CODE;
				id_o <= 16'hf000;
			end
		end
	end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench
	import bcf_pkg::*;
;
	localparam logic [15:0] EC = 16'h0c01;
	logic clk_i = 0;
	logic rst_i = 1;
	logic ce_i = 1;
	logic cyc_i = 0;
	logic stb_i = 0;
	logic we_i = 0;
	logic [17:0] adr_i = '0;
	logic [31:0] dat_i = '0;
	logic [31:0] dat_o, flag_set_i, q;
	logic ack_o, irq_o, err_load_i, alm_load_i, lost_inc_i, alm_inc_i;
	logic tbl_we_i, commit_pending_o;
	logic [15:0] err_code_i, err_id_i, alm_code_i, alm_id_i, tbl_dat_i;
	logic [1:0] tbl_sel_i;
	logic [6:0] st;
	logic [511:0] output_point_area_o;
	int cnt[7];
	int cb[7] = '{1, 2, 12, 13, 16, 17, 18};
	int miscompares = 0;
	int n_checks = 0;
	bcf_bridge i_dut (
		.*,
		.sel_i(4'hf),
		.tbl_adr_i(8'h00),
		.addr_detect_start_o(st[0]),
		.addr_check_start_o(st[1]),
		.param_commit_start_o(st[2]),
		.version_check_start_o(st[3]),
		.slave_param_start_o(st[4]),
		.batch_read_start_o(st[5]),
		.batch_write_start_o(st[6])
	);
	bcf_engine_model #(.CODE(EC)) i_eng (
		.clk_i(clk_i),
		.det_i(st[0]),
		.chk_i(st[1]),
		.prm_i(st[4]),
		.flag_set_o(flag_set_i),
		.err_load_o(err_load_i),
		.alm_load_o(alm_load_i),
		.lost_inc_o(lost_inc_i),
		.alm_inc_o(alm_inc_i),
		.tbl_we_o(tbl_we_i),
		.tbl_sel_o(tbl_sel_i),
		.code_o(err_code_i),
		.id_o(err_id_i)
	);
	// Alarm and table data share the engine code bus
	assign alm_code_i = err_code_i;
	assign alm_id_i = err_id_i;
	assign tbl_dat_i = err_code_i;
	always #10 clk_i = ~clk_i;
	// Count start pulses per action
	always @(posedge clk_i) begin
		for (int i = 0; i < 7; i++)
			cnt[i] <= rst_i ? 0 : cnt[i] + st[i];
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One classic cycle; q holds read data taken at the ack edge
	task automatic wb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= {a, 2'b00};
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		wb(0, a, 0);
		chk(q, e);
	endtask
	// Raise command bits, drop them, let the engine answer
	task automatic pulse(input logic [31:0] d);
		wb(1, BCF_CMD_IDX, d);
		wb(1, BCF_CMD_IDX, 0);
		repeat (8) @(posedge clk_i);
	endtask
	task automatic do_rst;
		rst_i <= 1;
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
	endtask
	task wrap_up;
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		wrap_up();
	end
	initial begin
		do_rst();
		rd(BCF_STATUS_IDX, 0);
		wb(1, 16'h0100, 32'h1234);
		rd(16'h0100, 0);
		// Each action command, not the clear: edge, held level, release
		for (int i = 0; i < 7; i++) begin
			wb(1, BCF_CMD_IDX, 32'h1 << cb[i]);
			pulse(32'h1 << cb[i]);
			chk(cnt[i], 1);
		end
		chk(commit_pending_o, 1);
		do_rst();
		chk(commit_pending_o, 0);
		pulse(32'h2);
		pulse(32'h4);
		rd(BCF_STATUS_IDX, 32'h1_0062);
		rd(BCF_DISC_TABLE_IDX, EC);
		rd(BCF_IRQ_STAT_IDX, 32'h6);
		chk(irq_o, 0);
		wb(1, BCF_IRQ_EN_IDX, 32'h2);
		chk(irq_o, 1);
		wb(1, BCF_IRQ_CLR_IDX, 32'h6);
		chk(irq_o, 0);
		// Clear while parameter access is not done
		pulse(32'h1);
		rd(BCF_STATUS_IDX, 32'h20);
		rd(BCF_ERRCODE_IDX, EC);
		rd(BCF_LOSTCNT_IDX, 1);
		rd(BCF_ALMCODE_IDX, 0);
		rd(BCF_ALMCNT_IDX, 0);
		rd(BCF_ALARM_TABLE_IDX, 0);
		rd(BCF_DISC_TABLE_IDX, 0);
		pulse(32'h1_0000);
		pulse(32'h1);
		rd(BCF_STATUS_IDX, 32'h2_0000);
		rd(BCF_ERRID_IDX, 0);
		rd(BCF_LOSTCNT_IDX, 0);
		// Frozen while enable is low: no answer, no output change
		ce_i <= 0;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= 1;
		adr_i <= {BCF_OUT_BASE_IDX + 16'h2, 2'b00};
		dat_i <= 32'h1;
		repeat (4) @(posedge clk_i);
		chk(ack_o, 0);
		chk(output_point_area_o[47:32], 0);
		ce_i <= 1;
		wb(1, BCF_OUT_BASE_IDX + 16'h2, 32'h1);
		chk(output_point_area_o[47:32], 16'h1);
		// Slaves at points 30 and 50, plus the last point
		wb(1, BCF_OUT_BASE_IDX + 16'h1, 32'hc000);
		wb(1, BCF_OUT_BASE_IDX + 16'h3, 32'hfffc);
		wb(1, BCF_OUT_BASE_IDX + 16'h4, 32'h0003);
		wb(1, BCF_OUT_BASE_IDX + 16'h1f, 32'h8000);
		chk(output_point_area_o[31:0], 32'hc000_0000);
		chk(output_point_area_o[66:48], 19'h3fffc);
		chk(output_point_area_o[511:496], 16'h8000);
		rd(BCF_OUT_BASE_IDX + 16'h3, 32'hfffc);
		wrap_up();
	end
endmodule
